// ### dv/prescaler_sva.sv
module prescaler_sva
  import prescaler_pkg::*;
(
  input wire logic              i_ref_clk,
  input wire logic              i_rst_n,
  input wire logic [ADDR_W-1:0] i_address,
  input wire logic              i_read,
  input wire logic              i_write,
  input wire logic [DATA_W-1:0] i_writedata,
  input wire logic [3:0]        i_byteenable,
  input wire logic [DATA_W-1:0] o_readdata,
  input wire logic              o_waitrequest,
  input wire logic [TIMERS-1:0] i_external_count_pin,
  input wire logic [TIMERS-1:0] o_timer_tick,
  input wire logic              o_shared_prescaler_reset,
  input wire logic              o_second_prescaler_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cs_q [TIMERS]; // Shadow of select fields
  logic       hold_q;        // Shadow of hold mode
  logic       done_wr;       // Write completing this edge
  assign done_wr = i_write && !o_waitrequest && i_byteenable[0];
  // Track register writes
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold_q <= 1'b0;
      cs_q   <= '{default: CS_STOP};
    end else if (done_wr) begin
      if (i_address == GEN_CTRL_OFS) hold_q <= i_writedata[7];
      for (int k = 0; k < TIMERS; k++)
        if (i_address == 8'(CS0_OFS + 4 * k)) cs_q[k] <= i_writedata[2:0];
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  a_wait_answer: assert property ((i_read || i_write) && o_waitrequest
    |=> !o_waitrequest) else $error("no bus answer");
  a_wait_once: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("waitrequest low too long");
  a_shared_clear: assert property (
    o_shared_prescaler_reset && !hold_q |=> !o_shared_prescaler_reset)
    else $error("shared reset not cleared");
  a_hold_keep: assert property (
    done_wr && i_address == GEN_CTRL_OFS && i_writedata[7] |=>
    o_shared_prescaler_reset == $past(i_writedata[0]) &&
    o_second_prescaler_reset == $past(i_writedata[1]))
    else $error("held reset bits wrong");
  a_hold_release: assert property (
    done_wr && i_address == GEN_CTRL_OFS && !i_writedata[7] |=> ##1
    !o_shared_prescaler_reset && !o_second_prescaler_reset)
    else $error("reset bits not released");
  for (genvar i = 0; i < TIMERS; i++) begin : g_tmr
    a_stop_quiet: assert property (
      (cs_q[i] == CS_STOP)[*3] |-> !o_timer_tick[i])
      else $error("stopped timer ticked");
    a_every_cycle: assert property (
      (cs_q[i] == CS_DIV1)[*3] |-> o_timer_tick[i])
      else $error("missing direct tick");
    a_div8_gap: assert property (
      cs_q[i] == CS_DIV8 && $past(cs_q[i]) == CS_DIV8 && o_timer_tick[i]
      |=> (cs_q[i] != CS_DIV8 || !o_timer_tick[i])[*7])
      else $error("divide by 8 tick too soon");
    a_pin_rise: assert property (
      (cs_q[i] == CS_RISE)[*4] ##0 $rose(i_external_count_pin[i])
      |-> ##[2:4] o_timer_tick[i]) else $error("rise not counted");
    a_pin_fall: assert property (
      (cs_q[i] == CS_FALL)[*4] ##0 $fell(i_external_count_pin[i])
      |-> ##[2:4] o_timer_tick[i]) else $error("fall not counted");
  end
endmodule // prescaler_sva
bind shared_timer_prescaler prescaler_sva prescaler_sva_inst (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_address(i_address),
  .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
  .i_byteenable(i_byteenable), .o_readdata(o_readdata),
  .o_waitrequest(o_waitrequest), .o_timer_tick(o_timer_tick),
  .i_external_count_pin(i_external_count_pin),
  .o_shared_prescaler_reset(o_shared_prescaler_reset),
  .o_second_prescaler_reset(o_second_prescaler_reset));

// ### dv/test_shared_timer_prescaler.sv
module test_shared_timer_prescaler
  import prescaler_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, read, write, clear, srst, s2rst, waitreq;
  logic [7:0]  address;
  logic [31:0] wdata, rdata, q;
  logic [3:0]  be, half;
  logic [2:0]  pin, tick, run;
  logic [15:0] ticks [TIMERS], rises [TIMERS], falls [TIMERS];
  logic [2:0]  cfg [TIMERS]; // Select codes under test
  int          n_errors = 0;
  int          n_checks = 0;
  shared_timer_prescaler shared_timer_prescaler_inst (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_address(address),
    .i_read(read), .i_write(write), .i_writedata(wdata),
    .i_byteenable(be), .o_readdata(rdata), .o_waitrequest(waitreq),
    .i_external_count_pin(pin), .o_timer_tick(tick),
    .o_shared_prescaler_reset(srst), .o_second_prescaler_reset(s2rst));
  timer_side_model timer_side_model_inst (
    .i_ref_clk(clk), .i_clear(clear), .i_run(run), .i_half(half),
    .i_timer_tick(tick), .o_pin(pin), .o_ticks(ticks),
    .o_rises(rises), .o_falls(falls));
  always #5 clk = ~clk;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One Avalon access, held until waitrequest is seen low
  task automatic bus_op(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    address <= a;
    wdata   <= d;
    read    <= !wr;
    write   <= wr;
    // Waitrequest is looked at on rising edges only
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    if (waitreq !== 1'b0) begin
      n_errors++;
      tally_and_finish();
    end
    // Data taken and request released at the answering edge
    r = rdata;
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] exp_count(logic [2:0] cs, int w);
    case (cs)
      CS_DIV1:    return 32'(w);
      CS_DIV8:    return 32'(w / 8);
      CS_DIV64:   return 32'(w / 64);
      CS_DIV256:  return 32'(w / 256);
      CS_DIV1024: return 32'(w / 1024);
      default:    return 32'h0;
    endcase
  endfunction
  task automatic set_cs;
    for (int k = 0; k < TIMERS; k++)
      bus_op(1'b1, 8'(CS0_OFS + 4 * k), {29'h0, cfg[k]}, q);
  endtask
  // Clear tallies, run pins, count over w edges
  task automatic measure(input int w, input logic [2:0] pins);
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
    run   <= pins;
    repeat (w) @(posedge clk);
    @(posedge clk);
  endtask
  task automatic run_rates(input int w);
    set_cs();
    measure(w, 3'h0);
    for (int k = 0; k < TIMERS; k++)
      check({16'h0, ticks[k]}, exp_count(cfg[k], w));
    $display("rate test %0d %0d %0d done", cfg[0], cfg[1], cfg[2]);
  endtask
  initial begin
    clk = 0; rst_n = 0; read = 0; write = 0; address = 8'h00;
    wdata = 32'h0; be = 4'hF; clear = 1; run = 3'h0; half = 4'h3;
    void'($urandom(32'hB516));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    bus_op(1'b0, GEN_CTRL_OFS, 32'h0, q);
    check(q, 32'(GEN_CTRL_RESET));
    for (int k = 0; k < TIMERS; k++) begin
      bus_op(1'b0, 8'(CS0_OFS + 4 * k), 32'h0, q);
      check(q, 32'(CS_RESET));
    end
    bus_op(1'b1, 8'h20, 32'hFF, q);
    bus_op(1'b0, 8'h20, 32'h0, q);
    check(q, 32'h0);
    be <= 4'h0;
    bus_op(1'b1, GEN_CTRL_OFS, 32'h82, q);
    be <= 4'hF;
    bus_op(1'b0, GEN_CTRL_OFS, 32'h0, q);
    check(q, 32'h0);
    $display("register test done");
    cfg = '{CS_DIV1, CS_DIV8, CS_DIV64};
    run_rates(2048);
    cfg = '{CS_DIV256, CS_DIV1024, CS_STOP};
    run_rates(2048);
    repeat (3) begin
      for (int k = 0; k < TIMERS; k++) cfg[k] = 3'($urandom_range(5));
      run_rates(2048);
    end
    cfg = '{CS_DIV64, CS_DIV64, CS_DIV8};
    set_cs();
    bus_op(1'b1, GEN_CTRL_OFS, 32'h81, q);
    measure(300, 3'h0);
    for (int k = 0; k < TIMERS; k++)
      check({16'h0, ticks[k]}, 32'h0);
    check({31'h0, srst}, 32'h1);
    bus_op(1'b0, GEN_CTRL_OFS, 32'h0, q);
    check(q, 32'h81);
    bus_op(1'b0, STATUS_OFS, 32'h0, q);
    check(q, 32'h0);
    bus_op(1'b1, GEN_CTRL_OFS, 32'h0, q);
    measure(596, 3'h0);
    for (int k = 0; k < TIMERS; k++)
      check({16'h0, ticks[k]}, exp_count(cfg[k], 596));
    bus_op(1'b1, GEN_CTRL_OFS, 32'h01, q);
    bus_op(1'b0, GEN_CTRL_OFS, 32'h0, q);
    check(q, 32'h0);
    bus_op(1'b1, GEN_CTRL_OFS, 32'h82, q);
    check({31'h0, s2rst}, 32'h1);
    bus_op(1'b1, GEN_CTRL_OFS, 32'h00, q);
    check({31'h0, s2rst}, 32'h0);
    $display("prescaler reset test done");
    // Pins are still while the source is switched
    cfg = '{CS_FALL, CS_RISE, CS_RISE};
    set_cs();
    half <= 4'(3 + $urandom_range(5));
    measure(400, 3'h7);
    run <= 3'h0;
    repeat (11) @(posedge clk);
    check({16'h0, ticks[0]}, {16'h0, falls[0]});
    check({16'h0, ticks[1]}, {16'h0, rises[1]});
    check({16'h0, ticks[2]}, {16'h0, rises[2]});
    bus_op(1'b0, STATUS_OFS, 32'h0, q);
    check({29'h0, q[18:16]}, {29'h0, pin});
    $display("pin test done");
    tally_and_finish();
  end
endmodule // test_shared_timer_prescaler

// ### dv/timer_side_model.sv
// ****************************************
// Timers and count pins on the far side
// ****************************************
module timer_side_model
  import prescaler_pkg::*;
(
  // Clock and control
  input  wire logic              i_ref_clk,
  input  wire logic              i_clear,
  input  wire logic [TIMERS-1:0] i_run,
  input  wire logic [3:0]        i_half,
  // Tick inputs and pin outputs
  input  wire logic [TIMERS-1:0] i_timer_tick,
  output logic      [TIMERS-1:0] o_pin,
  // Tallies
  output logic      [15:0]       o_ticks [TIMERS],
  output logic      [15:0]       o_rises [TIMERS],
  output logic      [15:0]       o_falls [TIMERS]
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] phase [TIMERS]; // Cycles spent in current pin level
  initial begin
    o_pin = '0;
    phase = '{default: 4'h0};
  end
  // Count ticks, toggle pins every i_half cycles
  always @(posedge i_ref_clk) begin
    for (int k = 0; k < TIMERS; k++) begin
      if (i_clear) begin
        o_ticks[k] <= 16'h0000;
        o_rises[k] <= 16'h0000;
        o_falls[k] <= 16'h0000;
      end else if (i_timer_tick[k]) begin
        o_ticks[k] <= o_ticks[k] + 16'h0001;
      end
      // Stopped pin holds its level
      if (i_run[k] && !i_clear) begin
        phase[k] <= phase[k] + 4'h1;
        // Each level lasts i_half >= 3 cycles
        if (phase[k] == i_half - 4'h1) begin
          phase[k] <= 4'h0;
          o_pin[k] <= ~o_pin[k];
          if (o_pin[k]) o_falls[k] <= o_falls[k] + 16'h0001;
          else o_rises[k] <= o_rises[k] + 16'h0001;
        end
      end
    end
  end
endmodule // timer_side_model

// ### logic/prescaler_pkg.sv
// ****************************************************************
// Shared timer prescaler constants
// ****************************************************************
package prescaler_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int ADDR_W = 8;   // Byte address width
  localparam int DATA_W = 32;  // Avalon data width
  localparam int TIMERS = 3;   // Timers sharing the prescaler
  localparam int CS_W   = 3;   // Clock select field width
  localparam int PRE_W  = 10;  // Prescaler counter width

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] GEN_CTRL_OFS = 8'h00; // general_timer_control
  localparam logic [7:0] CS0_OFS      = 8'h04; // Timer 0 clock select
  localparam logic [7:0] CS1_OFS      = 8'h08; // Timer 1 clock select
  localparam logic [7:0] CS2_OFS      = 8'h0C; // Timer 2 clock select
  localparam logic [7:0] STATUS_OFS   = 8'h10; // Prescaler and pin state

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int SYNC_HOLD_BIT     = 7;  // sync_hold_mode
  localparam int SECOND_RST_BIT    = 1;  // second_prescaler_reset
  localparam int SHARED_RST_BIT    = 0;  // shared_prescaler_reset
  localparam int STATUS_PIN_POS    = 16; // Synchronised pin levels
  localparam logic [7:0] GEN_CTRL_RESET = 8'h00;
  localparam logic [2:0] CS_RESET       = 3'h0;
  localparam logic [9:0] PRE_RESET      = 10'h000;

  // ****************************************************************
  // Clock select codes
  // ****************************************************************
  localparam logic [2:0] CS_STOP  = 3'h0; // No source
  localparam logic [2:0] CS_DIV1  = 3'h1; // Every clock
  localparam logic [2:0] CS_DIV8  = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256  = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_FALL  = 3'h6; // Pin falling edge
  localparam logic [2:0] CS_RISE  = 3'h7; // Pin rising edge

  // ****************************************************************
  // Prescaler tap masks (tap fires when masked bits are all ones)
  // ****************************************************************
  localparam logic [9:0] TAP8_MASK    = 10'h007;
  localparam logic [9:0] TAP64_MASK   = 10'h03F;
  localparam logic [9:0] TAP256_MASK  = 10'h0FF;
  localparam logic [9:0] TAP1024_MASK = 10'h3FF;

endpackage : prescaler_pkg

// ### logic/shared_timer_prescaler.sv
module shared_timer_prescaler
  import prescaler_pkg::*;
(
  // Clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_n,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] i_address,
  input  wire logic              i_read,
  input  wire logic              i_write,
  input  wire logic [DATA_W-1:0] i_writedata,
  input  wire logic [3:0]        i_byteenable,
  output logic      [DATA_W-1:0] o_readdata,
  output logic                   o_waitrequest,
  // External count pins
  input  wire logic [TIMERS-1:0] i_external_count_pin,
  // Timer side
  output logic      [TIMERS-1:0] o_timer_tick,
  output logic                   o_shared_prescaler_reset,
  output logic                   o_second_prescaler_reset
);

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Tap fires when all masked counter bits are ones
  function automatic logic tap_hit(input logic [PRE_W-1:0] cnt,
                                   input logic [PRE_W-1:0] mask);
    tap_hit = ((cnt & mask) == mask);
  endfunction

  // Picks one timer's tick source from its select code
  function automatic logic pick_tick(input logic [CS_W-1:0] cs,
                                     input logic [3:0]      taps,
                                     input logic            rise,
                                     input logic            fall);
    logic t;
    t = 1'b0;
    unique case (cs)
      CS_STOP:    t = 1'b0;
      CS_DIV1:    t = 1'b1;
      CS_DIV8:    t = taps[0];
      CS_DIV64:   t = taps[1];
      CS_DIV256:  t = taps[2];
      CS_DIV1024: t = taps[3];
      CS_FALL:    t = fall;
      CS_RISE:    t = rise;
    endcase
    pick_tick = t;
  endfunction

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta;  // First reset stage
  logic rst_sync;  // Released reset, active high means running

  // Releases the asynchronous reset through two flops
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic                  sync_hold_mode;      // Hold mode bit
  logic                  shared_rst;          // Shared prescaler reset
  logic                  second_rst;          // Second prescaler reset
  logic [CS_W-1:0]       clock_select_field [TIMERS]; // Per timer
  logic                  waitreq;             // Wait toward master
  logic [DATA_W-1:0]     rdata;               // Read data register
  logic                  next_sync_hold_mode;
  logic                  next_shared_rst;
  logic                  next_second_rst;
  logic [CS_W-1:0]       next_cs [TIMERS];
  logic                  next_waitreq;
  logic [DATA_W-1:0]     next_rdata;
  logic                  req;                 // Read or write pending
  logic                  commit;              // Access completes now
  logic                  lane0;               // Low byte written

  // ****************************************************************
  // Prescaler, pin and tick state
  // ****************************************************************
  logic [PRE_W-1:0]      pre_cnt;             // Free running counter
  logic [PRE_W-1:0]      next_pre_cnt;
  logic [3:0]            taps;                // Tap pulses this cycle
  logic [TIMERS-1:0]     pin_latch;           // Clock-high latch
  logic [TIMERS-1:0]     pin_meta;            // First flop stage
  logic [TIMERS-1:0]     pin_sync;            // Second flop stage
  logic [TIMERS-1:0]     pin_prev;            // Edge detector memory
  logic [TIMERS-1:0]     pin_rise;            // Rising edge seen
  logic [TIMERS-1:0]     pin_fall;            // Falling edge seen
  logic [TIMERS-1:0]     tick;                // Registered ticks
  logic [TIMERS-1:0]     next_tick;

  // ****************************************************************
  // Bus access and control register
  // ****************************************************************

  // Waitrequest drops one cycle after a request, access then commits
  assign req    = i_read | i_write;
  assign commit = req & ~waitreq;
  assign lane0  = i_write & commit & i_byteenable[0];

  // Next values for bus handshake, read data and control bits
  always_comb begin
    next_waitreq        = 1'b1;
    next_rdata          = rdata;
    next_sync_hold_mode = sync_hold_mode;
    next_shared_rst     = shared_rst;
    next_second_rst     = second_rst;
    for (int i = 0; i < TIMERS; i++) begin
      next_cs[i] = clock_select_field[i];
    end
    // Answer a new request after one cycle
    if (req && waitreq) begin
      next_waitreq = 1'b0;
      next_rdata   = '0;
      if (i_read) begin
        unique case (i_address)
          GEN_CTRL_OFS: begin
            next_rdata[SYNC_HOLD_BIT]  = sync_hold_mode;
            next_rdata[SECOND_RST_BIT] = second_rst;
            next_rdata[SHARED_RST_BIT] = shared_rst;
          end
          CS0_OFS: next_rdata[CS_W-1:0] = clock_select_field[0];
          CS1_OFS: next_rdata[CS_W-1:0] = clock_select_field[1];
          CS2_OFS: next_rdata[CS_W-1:0] = clock_select_field[2];
          STATUS_OFS: begin
            next_rdata[PRE_W-1:0] = pre_cnt;
            next_rdata[STATUS_PIN_POS +: TIMERS] = pin_sync;
          end
          // Unmapped addresses read zero
          default: next_rdata = '0;
        endcase
      end
    end
    // Reset bits self-clear whenever hold mode is off
    if (!sync_hold_mode) begin
      next_shared_rst = 1'b0;
      next_second_rst = 1'b0;
    end
    // Writes take effect at the committing edge
    if (lane0) begin
      unique case (i_address)
        GEN_CTRL_OFS: begin
          next_sync_hold_mode = i_writedata[SYNC_HOLD_BIT];
          // Written value held for as long as hold mode stays set
          next_shared_rst = i_writedata[SHARED_RST_BIT];
          next_second_rst = i_writedata[SECOND_RST_BIT];
        end
        CS0_OFS: next_cs[0] = i_writedata[CS_W-1:0];
        CS1_OFS: next_cs[1] = i_writedata[CS_W-1:0];
        CS2_OFS: next_cs[2] = i_writedata[CS_W-1:0];
        // Unmapped writes are dropped
        default: next_sync_hold_mode = sync_hold_mode;
      endcase
    end
  end

  // Registers bus and control state
  always_ff @(posedge i_ref_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      waitreq        <= 1'b1;
      rdata          <= '0;
      sync_hold_mode <= GEN_CTRL_RESET[SYNC_HOLD_BIT];
      shared_rst     <= GEN_CTRL_RESET[SHARED_RST_BIT];
      second_rst     <= GEN_CTRL_RESET[SECOND_RST_BIT];
      for (int i = 0; i < TIMERS; i++) begin
        clock_select_field[i] <= CS_RESET;
      end
    end else begin
      waitreq        <= next_waitreq;
      rdata          <= next_rdata;
      sync_hold_mode <= next_sync_hold_mode;
      shared_rst     <= next_shared_rst;
      second_rst     <= next_second_rst;
      for (int i = 0; i < TIMERS; i++) begin
        clock_select_field[i] <= next_cs[i];
      end
    end
  end

  // ****************************************************************
  // Shared prescaler
  // ****************************************************************

  // Counts every cycle outside shared reset, whatever the timers select
  always_comb begin
    if (shared_rst) begin
      next_pre_cnt = PRE_RESET;
    end else begin
      next_pre_cnt = pre_cnt + 10'h001;
    end
  end

  // Tap pulses, none while the prescaler is held in reset
  always_comb begin
    taps[0] = ~shared_rst & tap_hit(pre_cnt, TAP8_MASK);
    taps[1] = ~shared_rst & tap_hit(pre_cnt, TAP64_MASK);
    taps[2] = ~shared_rst & tap_hit(pre_cnt, TAP256_MASK);
    taps[3] = ~shared_rst & tap_hit(pre_cnt, TAP1024_MASK);
  end

  // Registers the prescaler counter
  always_ff @(posedge i_ref_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      pre_cnt <= PRE_RESET;
    end else begin
      pre_cnt <= next_pre_cnt;
    end
  end

  // ****************************************************************
  // External pin sampling
  // ****************************************************************

  // Latch open while the clock is high
  always_latch begin
    if (i_ref_clk) begin
      pin_latch <= i_external_count_pin;
    end
  end

  // Two rising-edge stages plus edge memory
  always_ff @(posedge i_ref_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end else begin
      pin_meta <= pin_latch;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Edge detector on the synchronised level
  always_comb begin
    pin_rise = pin_sync & ~pin_prev;
    pin_fall = ~pin_sync & pin_prev;
  end

  // ****************************************************************
  // Tick selection
  // ****************************************************************

  // Each timer picks its own source from the shared taps
  always_comb begin
    for (int i = 0; i < TIMERS; i++) begin
      // Phase not aligned on enable, first tap within N+1 cycles
      next_tick[i] = pick_tick(clock_select_field[i], taps,
                               pin_rise[i], pin_fall[i]);
    end
  end

  // Registers the ticks, pin path totals 2.5 to 3.5 cycles
  always_ff @(posedge i_ref_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      tick <= '0;
    end else begin
      tick <= next_tick;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_readdata               = rdata;
  assign o_waitrequest            = waitreq;
  assign o_timer_tick             = tick;
  assign o_shared_prescaler_reset = shared_rst;
  assign o_second_prescaler_reset = second_rst;

endmodule // shared_timer_prescaler
